// ---- inc/mas_map.svh ----
`ifndef MAS_MAP_SVH
`define MAS_MAP_SVH

// ---------------------------------------------------------------
// serial slave address and commands
// ---------------------------------------------------------------
`define MAS_DEV_ADDR 7'h0A
`define MAS_CMD_TEMP 8'h00
`define MAS_CMD_MOD 8'h01
`define MAS_CMD_LOOP 8'h02
`define MAS_CMD_USER 8'h03
`define MAS_CMD_BIAS_DAC 8'h04
`define MAS_CMD_MOD_DAC 8'h05

// ---------------------------------------------------------------
// user result register fields
// ---------------------------------------------------------------
`define MAS_USER_DATA_MSB 9
`define MAS_USER_SRC_LSB 10
`define MAS_USER_SRC_MSB 12
`define MAS_USER_VALID_BIT 15
`define MAS_SEL_MSB 2

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define MAS_CODE_RST 10'h000
`define MAS_CONV_TIME_US 1000
`define MAS_CLK_MHZ 20
`define MAS_CONV_CYCLES (`MAS_CONV_TIME_US * `MAS_CLK_MHZ)

`endif

// ---- inc/mas_pkg.sv ----
package mas_pkg;
  // multiplexer sources, order fixes the select code
  typedef enum logic [2:0] {
    SRC_SOURCE_CURRENT,
    SRC_MOD_CURRENT,
    SRC_LASER_DIODE_VOLTAGE,
    SRC_MONITOR_DIODE_CURRENT,
    SRC_TERM_VOLTAGE,
    SRC_DIE_TEMP
  } mas_src_t;

  typedef enum logic [1:0] {
    SLOT_TEMP,
    SLOT_MOD,
    SLOT_LOOP,
    SLOT_USER
  } mas_slot_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK,
    ST_DONE
  } mas_i2c_state_t;
endpackage : mas_pkg

// ---- inc/mas_seq_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface mas_seq_if;
  import mas_pkg::*;
  mas_slot_t slot;
  mas_src_t mux_sel;
  mas_src_t user_sel;
  logic apc_mode;
  logic conv_done;
  mas_slot_t done_slot;
  mas_src_t done_src;
  logic [9:0] conv_code;
  modport seq (input user_sel, apc_mode,
    output slot, mux_sel, conv_done, done_slot, done_src, conv_code);
  modport core (output user_sel, apc_mode,
    input slot, mux_sel, conv_done, done_slot, done_src, conv_code);
endinterface : mas_seq_if
`default_nettype wire

// ---- core/mas_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mas_map.svh"
module mas_seq #(
  parameter int unsigned CONV_CYCLES = `MAS_CONV_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  mas_seq_if.seq sq,
  input wire logic [9:0] adc_code,
  output logic adc_start
);
  import mas_pkg::*;

  logic [15:0] timer_reg;
  mas_slot_t slot_reg;
  mas_src_t sel_reg;
  logic start_reg;
  logic done_reg;
  mas_slot_t done_slot_reg;
  mas_src_t done_src_reg;
  logic [9:0] code_reg;

  // ---------------------------------------------------------------
  // slot plan
  // ---------------------------------------------------------------
  function automatic mas_src_t slot_src(input mas_slot_t s,
      input logic apc, input mas_src_t usr);
    case (s)
      SLOT_TEMP: slot_src = SRC_DIE_TEMP;
      SLOT_MOD: slot_src = SRC_MOD_CURRENT;
      SLOT_LOOP: slot_src = apc ? SRC_MONITOR_DIODE_CURRENT
                                : SRC_SOURCE_CURRENT;
      default: slot_src = usr;
    endcase
  endfunction : slot_src

  wire last_cycle = (timer_reg == 16'(CONV_CYCLES - 1));
  wire [1:0] slot_inc = 2'(slot_reg + 2'h1);
  wire mas_slot_t slot_next = mas_slot_t'(slot_inc);
  wire mas_src_t sel_next = slot_src(slot_next, sq.apc_mode, sq.user_sel);

  // ---------------------------------------------------------------
  // round timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_reg <= 16'h0000;
      slot_reg <= SLOT_TEMP;
      sel_reg <= SRC_DIE_TEMP;
      start_reg <= 1'b1;
      done_reg <= 1'b0;
      done_slot_reg <= SLOT_TEMP;
      done_src_reg <= SRC_DIE_TEMP;
      code_reg <= `MAS_CODE_RST;
    end else begin
      start_reg <= last_cycle;
      done_reg <= last_cycle;
      timer_reg <= last_cycle ? 16'h0000 : 16'(timer_reg + 16'h0001);
      if (last_cycle) begin
        code_reg <= adc_code;
        done_slot_reg <= slot_reg;
        done_src_reg <= sel_reg;
        slot_reg <= slot_next;
        sel_reg <= sel_next;
      end
    end
  end

  assign adc_start = start_reg;
  assign sq.slot = slot_reg;
  assign sq.mux_sel = sel_reg;
  assign sq.conv_done = done_reg;
  assign sq.done_slot = done_slot_reg;
  assign sq.done_src = done_src_reg;
  assign sq.conv_code = code_reg;
endmodule : mas_seq
`default_nettype wire

// ---- core/mas_top.sv ----
// Overview of operation
// - 10-bit results, 1 ms slots, endless four-slot round
// - multiplexer offers six selectable input sources
// - slot one temperature, slot two modulation current
// - slot three: monitor current in apc, else source
// - one shared register holds slot-three result
// - loop math and converter updates in user slot
// - latest temperature readable any time, round undisturbed
// - three-bit user select; value 2 is diode voltage
// - new select applies at next user slot
// - user completion stores data, sets valid, loads tag
// - read or write of user register clears valid; a same-cycle user completion keeps it set
// - tag names source of stored data
// - user register reads and writes differ in layout
// - controller off makes converter codes bus-writable
// - standalone fetches config from serial memory
// - slave address 0x0A, bytes 0x15 read, 0x14 write
// - sixteen bits, low byte first, msb first
`timescale 1ns/1ps
`default_nettype none
`include "mas_map.svh"
module mas_top #(
  parameter int unsigned CONV_CYCLES = `MAS_CONV_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [9:0] adc_code,
  output logic adc_start,
  output mas_pkg::mas_src_t adc_mux_sel,
  input wire logic apc_mode,
  input wire logic lpc_en,
  input wire logic standalone,
  input wire logic config_loaded,
  output logic config_fetch_req,
  input wire logic [9:0] servo_bias_code,
  input wire logic [9:0] servo_mod_code,
  output logic loop_update,
  output logic [9:0] bias_source_converter,
  output logic [9:0] modulation_converter
);
  import mas_pkg::*;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  mas_seq_if sq ();

  mas_seq #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_seq (
    .clk(clk),
    .reset(reset),
    .sq(sq.seq),
    .adc_code(adc_code),
    .adc_start(adc_start)
  );

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // three stages; a level is accepted only when stages two and three
  // agree, which also rejects a single-sample glitch on the bus
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_reg;
  logic sda_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_reg <= sda_sync_reg[2];
      end
      scl_prev_reg <= scl_reg;
      sda_prev_reg <= sda_reg;
    end
  end

  wire scl_rise = scl_reg & ~scl_prev_reg;
  wire scl_fall = ~scl_reg & scl_prev_reg;
  wire bus_start = scl_reg & scl_prev_reg & ~sda_reg & sda_prev_reg;
  wire bus_stop = scl_reg & scl_prev_reg & sda_reg & ~sda_prev_reg;

  // ---------------------------------------------------------------
  // result and setting registers
  // ---------------------------------------------------------------
  logic [9:0] temp_result_reg;
  logic [9:0] mod_current_result_reg;
  logic [9:0] loop_result_reg;
  logic [9:0] user_data_reg;
  mas_src_t user_src_reg;
  logic user_valid_reg;
  mas_src_t user_sel_reg;
  logic [9:0] bias_code_reg;
  logic [9:0] mod_code_reg;
  logic loop_update_reg;
  mas_slot_t slot_prev_reg;
  logic fetch_reg;

  // ---------------------------------------------------------------
  // serial slave state
  // ---------------------------------------------------------------
  mas_i2c_state_t state_reg;
  mas_i2c_state_t state_next;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [7:0] cmd_reg;
  logic [7:0] wlow_reg;
  logic [15:0] rd_word_reg;
  logic rw_reg;
  logic high_byte_reg;
  logic nack_reg;
  logic sda_oe_reg;

  // read word for a command; user register shows data, tag and valid
  function automatic logic [15:0] read_word(input logic [7:0] cmd,
      input logic [9:0] t, input logic [9:0] m, input logic [9:0] l,
      input logic [9:0] ud, input mas_src_t us, input logic uv,
      input logic [9:0] bc, input logic [9:0] mc);
    logic [15:0] w;
    w = 16'h0000;
    case (cmd)
      `MAS_CMD_TEMP: w[9:0] = t;
      `MAS_CMD_MOD: w[9:0] = m;
      `MAS_CMD_LOOP: w[9:0] = l;
      `MAS_CMD_USER: begin
        w[`MAS_USER_DATA_MSB:0] = ud;
        w[`MAS_USER_SRC_MSB:`MAS_USER_SRC_LSB] = us;
        w[`MAS_USER_VALID_BIT] = uv;
      end
      `MAS_CMD_BIAS_DAC: w[9:0] = bc;
      `MAS_CMD_MOD_DAC: w[9:0] = mc;
      default: w = 16'h0000;
    endcase
    read_word = w;
  endfunction : read_word

  wire byte_full = (bit_cnt_reg == 4'h8);
  // ack bits are not counted, so each byte starts from zero
  wire data_phase = (state_reg == ST_ADDR) | (state_reg == ST_CMD) |
    (state_reg == ST_WDATA) | (state_reg == ST_RDATA);
  wire addr_match = (rx_reg[7:1] == `MAS_DEV_ADDR);
  wire [15:0] rd_word = read_word(cmd_reg, temp_result_reg,
    mod_current_result_reg, loop_result_reg, user_data_reg,
    user_src_reg, user_valid_reg, bias_code_reg, mod_code_reg);
  wire [15:0] wr_word = {rx_reg, wlow_reg};

  // a write commits after the acknowledged high byte
  wire wr_commit = scl_fall & (state_reg == ST_WDATA_ACK) & high_byte_reg;
  // a read access starts when the read address byte is acknowledged
  wire rd_access = scl_fall & (state_reg == ST_ADDR_ACK) & rw_reg;
  wire user_cmd = (cmd_reg == `MAS_CMD_USER);
  wire user_touch = (wr_commit | rd_access) & user_cmd;
  wire dac_write = wr_commit & ~lpc_en;
  wire src_valid = (wr_word[`MAS_SEL_MSB:0] <= 3'h5);
  wire user_done = sq.conv_done & (sq.done_slot == SLOT_USER);

  // ---------------------------------------------------------------
  // serial slave next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: state_next = ST_IDLE;
      ST_ADDR: begin
        if (scl_fall & byte_full) begin
          state_next = addr_match ? ST_ADDR_ACK : ST_IDLE;
        end
      end
      ST_ADDR_ACK: begin
        if (scl_fall) begin
          state_next = rw_reg ? ST_RDATA : ST_CMD;
        end
      end
      ST_CMD: begin
        if (scl_fall & byte_full) begin
          state_next = ST_CMD_ACK;
        end
      end
      ST_CMD_ACK: begin
        if (scl_fall) begin
          state_next = ST_WDATA;
        end
      end
      ST_WDATA: begin
        if (scl_fall & byte_full) begin
          state_next = ST_WDATA_ACK;
        end
      end
      ST_WDATA_ACK: begin
        if (scl_fall) begin
          state_next = high_byte_reg ? ST_DONE : ST_WDATA;
        end
      end
      ST_RDATA: begin
        if (scl_fall & byte_full) begin
          state_next = ST_RDATA_ACK;
        end
      end
      ST_RDATA_ACK: begin
        // master acks the low byte, leaves the high byte unacked;
        // move on the fall so sda never changes with scl high
        if (scl_fall) begin
          state_next = (nack_reg | high_byte_reg) ? ST_DONE
                                                   : ST_RDATA;
        end
      end
      ST_DONE: state_next = ST_DONE;
      default: state_next = ST_IDLE;
    endcase
    if (bus_start) begin
      state_next = ST_ADDR;
    end else if (bus_stop) begin
      state_next = ST_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // serial slave datapath
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      cmd_reg <= 8'h00;
      wlow_reg <= 8'h00;
      rd_word_reg <= 16'h0000;
      rw_reg <= 1'b0;
      high_byte_reg <= 1'b0;
      nack_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      if (scl_rise & (state_reg == ST_RDATA_ACK)) begin
        nack_reg <= sda_reg;
      end
      if (bus_start) begin
        bit_cnt_reg <= 4'h0;
      end else if (scl_rise & ~byte_full & data_phase) begin
        rx_reg <= {rx_reg[6:0], sda_reg};
        bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
      end else if (scl_fall & byte_full) begin
        bit_cnt_reg <= 4'h0;
      end
      if (scl_fall & byte_full) begin
        if (state_reg == ST_ADDR) begin
          rw_reg <= rx_reg[0];
        end
        if (state_reg == ST_CMD) begin
          cmd_reg <= rx_reg;
          high_byte_reg <= 1'b0;
        end
      end
      if (scl_fall & (state_reg == ST_WDATA_ACK)) begin
        wlow_reg <= rx_reg;
        high_byte_reg <= 1'b1;
      end
      if (rd_access) begin
        // snapshot so both bytes come from one value
        rd_word_reg <= rd_word;
        tx_reg <= rd_word[7:0];
        high_byte_reg <= 1'b0;
      end else if (scl_fall & (state_reg == ST_RDATA) & ~byte_full) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end else if (scl_fall & (state_reg == ST_RDATA_ACK)) begin
        tx_reg <= rd_word_reg[15:8];
        high_byte_reg <= 1'b1;
      end
    end
  end

  // open drain: only ever pull low
  wire oe_next = (state_next == ST_ADDR_ACK) | (state_next == ST_CMD_ACK) |
    (state_next == ST_WDATA_ACK) | ((state_next == ST_RDATA) &
    ~(rd_access ? rd_word[7] :
      (state_reg == ST_RDATA_ACK) ? rd_word_reg[15] :
      (scl_fall & ~byte_full) ? tx_reg[6] : tx_reg[7]));

  always_ff @(posedge clk) begin
    if (reset) begin
      sda_oe_reg <= 1'b0;
    end else begin
      sda_oe_reg <= oe_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;

  // ---------------------------------------------------------------
  // conversion results
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      temp_result_reg <= `MAS_CODE_RST;
      mod_current_result_reg <= `MAS_CODE_RST;
      loop_result_reg <= `MAS_CODE_RST;
      user_data_reg <= `MAS_CODE_RST;
      user_src_reg <= SRC_DIE_TEMP;
      user_valid_reg <= 1'b0;
    end else begin
      if (sq.conv_done) begin
        case (sq.done_slot)
          SLOT_TEMP: temp_result_reg <= sq.conv_code;
          SLOT_MOD: mod_current_result_reg <= sq.conv_code;
          SLOT_LOOP: loop_result_reg <= sq.conv_code;
          default: begin
            user_data_reg <= sq.conv_code;
            user_src_reg <= sq.done_src;
          end
        endcase
      end
      // a completion in the same cycle as an access keeps valid set
      if (user_done) begin
        user_valid_reg <= 1'b1;
      end else if (user_touch) begin
        user_valid_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // user select, converters and loop timing
  // ---------------------------------------------------------------
  // the sequencer samples the select only as a user slot opens
  wire user_sel_wr = wr_commit & user_cmd & src_valid;
  wire loop_tick = (sq.slot == SLOT_USER) & (slot_prev_reg != SLOT_USER);

  always_ff @(posedge clk) begin
    if (reset) begin
      user_sel_reg <= SRC_DIE_TEMP;
      bias_code_reg <= `MAS_CODE_RST;
      mod_code_reg <= `MAS_CODE_RST;
      loop_update_reg <= 1'b0;
      slot_prev_reg <= SLOT_TEMP;
    end else begin
      slot_prev_reg <= sq.slot;
      loop_update_reg <= loop_tick & lpc_en;
      if (user_sel_wr) begin
        user_sel_reg <= mas_src_t'(wr_word[`MAS_SEL_MSB:0]);
      end
      if (lpc_en & loop_tick) begin
        bias_code_reg <= servo_bias_code;
        mod_code_reg <= servo_mod_code;
      end else if (dac_write & (cmd_reg == `MAS_CMD_BIAS_DAC)) begin
        bias_code_reg <= wr_word[9:0];
      end else if (dac_write & (cmd_reg == `MAS_CMD_MOD_DAC)) begin
        mod_code_reg <= wr_word[9:0];
      end
    end
  end

  assign sq.user_sel = user_sel_reg;
  assign sq.apc_mode = apc_mode;
  assign adc_mux_sel = sq.mux_sel;
  assign loop_update = loop_update_reg;
  assign bias_source_converter = bias_code_reg;
  assign modulation_converter = mod_code_reg;

  // ---------------------------------------------------------------
  // standalone configuration fetch
  // ---------------------------------------------------------------
  // the memory reader is outside; this only holds the request up
  always_ff @(posedge clk) begin
    if (reset) begin
      fetch_reg <= 1'b1;
    end else if (config_loaded | ~standalone) begin
      fetch_reg <= 1'b0;
    end
  end

  assign config_fetch_req = fetch_reg & standalone;
endmodule : mas_top
`default_nettype wire

// ---- test/mas_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module mas_assertions #(
  parameter int unsigned CONV_CYCLES = 20000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic adc_start,
  input wire mas_pkg::mas_src_t adc_mux_sel,
  input wire logic apc_mode,
  input wire logic lpc_en,
  input wire logic standalone,
  input wire logic config_fetch_req,
  input wire logic loop_update,
  input wire logic [9:0] bias_source_converter
);
  import mas_pkg::*;
  // ----------------------------------
  // slot tracking
  // ----------------------------------
  logic [31:0] gap_reg;
  logic [1:0] idx_reg;
  logic seen_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      gap_reg <= 32'h0;
      idx_reg <= 2'h0;
      seen_reg <= 1'h0;
    end else if (adc_start) begin
      gap_reg <= 32'h0;
      idx_reg <= idx_reg + 2'h1;
      seen_reg <= 1'h1;
    end else begin
      gap_reg <= gap_reg + 32'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  start_gap_a: assert property (seen_reg && adc_start |->
    gap_reg == CONV_CYCLES - 1) else $error("slot length wrong");
  start_due_a: assert property (seen_reg &&
    gap_reg == CONV_CYCLES - 1 |-> adc_start) else $error("slot overran");
  temp_slot_a: assert property (adc_start && idx_reg == 2'h0 |=>
    adc_mux_sel == SRC_DIE_TEMP) else $error("slot one source wrong");
  mod_slot_a: assert property (adc_start && idx_reg == 2'h1 |=>
    adc_mux_sel == SRC_MOD_CURRENT) else $error("slot two source wrong");
  loop_slot_a: assert property (adc_start && idx_reg == 2'h2 |=>
    adc_mux_sel == ($past(apc_mode) ? SRC_MONITOR_DIODE_CURRENT :
    SRC_SOURCE_CURRENT)) else $error("slot three source wrong");
  upd_slot_a: assert property (adc_start && idx_reg == 2'h3 && lpc_en
    |-> ##[0:2] loop_update) else $error("no loop update");
  upd_pulse_a: assert property (loop_update |-> $past(lpc_en)
    ##1 !loop_update [*8]) else $error("loop update misplaced");
  conv_hold_a: assert property (lpc_en && $past(lpc_en) &&
    $changed(bias_source_converter) |-> adc_start && idx_reg == 2'h3 ||
    idx_reg == 2'h0 && gap_reg < 32'h3) else $error("converter moved");
  fetch_gate_a: assert property (!standalone &&
    !$past(standalone) |-> !config_fetch_req) else $error("stray fetch");
  oe_scl_low_a: assert property ($changed(sda_oe) |->
    !scl_in) else $error("data moved with clock high");
  upd_c: cover property (loop_update);
  ccm_c: cover property (adc_start && idx_reg == 2'h2 && !apc_mode);
  ack_c: cover property ($rose(sda_oe));
endmodule : mas_assertions
bind mas_top mas_assertions #(.CONV_CYCLES(CONV_CYCLES)) chk (
  .clk(clk), .reset(reset), .scl_in(scl_in), .sda_oe(sda_oe),
  .adc_start(adc_start), .adc_mux_sel(adc_mux_sel), .apc_mode(apc_mode),
  .lpc_en(lpc_en), .standalone(standalone),
  .config_fetch_req(config_fetch_req), .loop_update(loop_update),
  .bias_source_converter(bias_source_converter)
);
`default_nettype wire

// ---- test/mas_bus_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module mas_bus_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ----------------------------------
  // bus master, each clock phase 8 clk
  // ----------------------------------
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  // sda only moves with scl low, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    hold(2);
    sda_low = !b;
    hold(6);
    scl = 1'h1;
    hold(4);
    r = sda;
    hold(4);
    scl = 1'h0;
  endtask : bit_io
  // wait out the device's late ack release before raising scl
  task automatic start;
    sda_low = 1'h0;
    hold(8);
    scl = 1'h1;
    hold(8);
    sda_low = 1'h1;
    hold(8);
    scl = 1'h0;
  endtask : start
  task automatic stop;
    sda_low = 1'h1;
    hold(8);
    scl = 1'h1;
    hold(8);
    sda_low = 1'h0;
    hold(8);
  endtask : stop
  task automatic xfer(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'h1, r);
    ack = !r;
  endtask : xfer
  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask : recv
  task automatic write_word(input logic [7:0] ab, input logic [7:0] cmd,
      input logic [15:0] d, output logic ok);
    logic a0, a1, a2, a3;
    start();
    xfer(ab, a0);
    xfer(cmd, a1);
    xfer(d[7:0], a2);
    xfer(d[15:8], a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask : write_word
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d,
      output logic ok);
    logic a0, a1, a2;
    start();
    xfer(8'h14, a0);
    xfer(cmd, a1);
    start();
    xfer(8'h15, a2);
    recv(1'h0, d[7:0]);
    recv(1'h1, d[15:8]);
    stop();
    ok = a0 & a1 & a2;
  endtask : read_word
endmodule : mas_bus_host
`default_nettype wire

// ---- test/test_monitor_adc_sequencer_i2c.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_monitor_adc_sequencer_i2c;
  import mas_pkg::*;
  localparam int unsigned CONV = 400;
  logic clk = 1'h0;
  logic reset, apc_mode, lpc_en, standalone, config_loaded;
  logic scl, host_low, sda_out, sda_oe, adc_start, config_fetch_req;
  logic loop_update;
  logic [9:0] adc_code = 10'h000;
  logic [9:0] servo_bias_code, servo_mod_code;
  logic [9:0] bias_source_converter, modulation_converter;
  mas_src_t adc_mux_sel;
  wire sda;
  int fail_count, checked;
  // ----------------------------------
  // bench wiring, sda pulled up
  // ----------------------------------
  assign sda = !(sda_oe || host_low);
  always #25 clk = ~clk;
  mas_top #(.CONV_CYCLES(CONV)) DUT (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .adc_code(adc_code),
    .adc_start(adc_start), .adc_mux_sel(adc_mux_sel),
    .apc_mode(apc_mode), .lpc_en(lpc_en), .standalone(standalone),
    .config_loaded(config_loaded), .config_fetch_req(config_fetch_req),
    .servo_bias_code(servo_bias_code), .servo_mod_code(servo_mod_code),
    .loop_update(loop_update),
    .bias_source_converter(bias_source_converter),
    .modulation_converter(modulation_converter)
  );
  mas_bus_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
  function automatic logic [9:0] code(input mas_src_t s);
    return 10'h041 * {7'h0, s} + 10'h041;
  endfunction : code
  always @(negedge clk) adc_code <= code(adc_mux_sel);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] cmd, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    host.read_word(cmd, d, ok);
    check({15'h0, ok}, 16'h0001);
    check(d, e);
  endtask : rd
  task automatic wr(input logic [7:0] ab, input logic [7:0] cmd,
      input logic [15:0] d, input logic ok_exp);
    logic ok;
    host.write_word(ab, cmd, d, ok);
    check({15'h0, ok}, {15'h0, ok_exp});
  endtask : wr
  // lands just after a user result, leaving most of a round free
  task automatic sync_round;
    int n;
    // temperature to modulation current only happens at slot two
    for (n = 0; n < 4000 && adc_mux_sel !== SRC_DIE_TEMP; n++)
      @(negedge clk);
    for (n = 0; n < 4000 && adc_mux_sel !== SRC_MOD_CURRENT; n++)
      @(negedge clk);
    repeat (3 * CONV + 10) @(negedge clk);
  endtask : sync_round
  task automatic user_case(input logic [2:0] v);
    logic [15:0] e;
    e = {1'h1, 2'h0, v, code(mas_src_t'(v))};
    sync_round();
    wr(8'h14, 8'h03, {13'h0, v}, 1'h1);
    sync_round();
    rd(8'h03, e);
    e[15] = 1'h0;
    rd(8'h03, e);
  endtask : user_case
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    reset = 1'h1;
    apc_mode = 1'h1;
    lpc_en = 1'h1;
    standalone = 1'h1;
    config_loaded = 1'h0;
    servo_bias_code = 10'h155;
    servo_mod_code = 10'h0CA;
    fail_count = 0;
    checked = 0;
    repeat (8) @(negedge clk);
    reset = 1'h0;
    repeat (6) @(negedge clk);
    check({13'h0, adc_mux_sel}, 16'h0005);
    check({15'h0, sda_oe}, 16'h0000);
    check({6'h0, bias_source_converter}, 16'h0000);
    check({15'h0, config_fetch_req}, 16'h0001);
    config_loaded = 1'h1;
    repeat (4) @(negedge clk);
    check({15'h0, config_fetch_req}, 16'h0000);
    config_loaded = 1'h0;
    standalone = 1'h0;
    for (int a = 1; a >= 0; a--) begin
      sync_round();
      apc_mode = a[0];
      rd(8'h00, {6'h0, code(SRC_DIE_TEMP)});
      rd(8'h01, {6'h0, code(SRC_MOD_CURRENT)});
      rd(8'h02, {6'h0, code(a[0] ? SRC_MONITOR_DIODE_CURRENT :
        SRC_SOURCE_CURRENT)});
    end
    for (int s = 0; s < 6; s++) user_case(3'(s));
    sync_round();
    wr(8'h14, 8'h03, 16'h0002, 1'h1);
    rd(8'h03, {3'h0, 3'h5, code(SRC_DIE_TEMP)});
    wr(8'h14, 8'h03, 16'h0006, 1'h1);
    sync_round();
    rd(8'h03, {3'h4, 3'h2, code(SRC_LASER_DIODE_VOLTAGE)});
    wr(8'h16, 8'h03, 16'h0000, 1'h0);
    sync_round();
    check({6'h0, bias_source_converter}, 16'h0155);
    check({6'h0, modulation_converter}, 16'h00CA);
    wr(8'h14, 8'h04, 16'h02A5, 1'h1);
    check({6'h0, bias_source_converter}, 16'h0155);
    lpc_en = 1'h0;
    servo_bias_code = 10'h0F0;
    wr(8'h14, 8'h04, 16'h02A5, 1'h1);
    wr(8'h14, 8'h05, 16'h013C, 1'h1);
    check({6'h0, bias_source_converter}, 16'h02A5);
    check({6'h0, modulation_converter}, 16'h013C);
    rd(8'h04, 16'h02A5);
    sync_round();
    check({6'h0, bias_source_converter}, 16'h02A5);
    lpc_en = 1'h1;
    sync_round();
    check({6'h0, bias_source_converter}, 16'h00F0);
    give_verdict();
  end
endmodule : test_monitor_adc_sequencer_i2c
`default_nettype wire
